// *** common/sbs_params.svh ***
`ifndef SBS_PARAMS_SVH
`define SBS_PARAMS_SVH
// register indices; the byte address on the bus is index * 4
`define SBS_IDX_STATUS     8'h0B
`define SBS_IDX_CONFIG_ONE 8'h0C
`define SBS_IDX_CONFIG_TWO 8'h0D
`define SBS_IDX_SENSOR_TWO 8'h0E
`define SBS_IDX_INT_MASK   8'h0F
`define SBS_IDX_INT_STAT   8'h10
`define SBS_IDX_DATA       8'h11
// status field positions
`define SBS_ST_WMRK_BIT    7
`define SBS_ST_OVF_BIT     6
// config one: mode in bits 1:0, read order (0 fifo, 1 lifo) in bit 2
`define SBS_CFG1_MODE_LSB  0
`define SBS_CFG1_ORDER_BIT 2
// config two: watermark level in 5:0, flush in 7
`define SBS_CFG2_FLUSH_BIT 7
// sensor config two: fast read in bit 0
`define SBS_SEN2_FREAD_BIT 0
// interrupt status/mask: watermark bit 0, overflow bit 1
`define SBS_IRQ_WMRK_BIT   0
`define SBS_IRQ_OVF_BIT    1
// interrupt mask: route watermark to pin two in bit 7
`define SBS_IRQ_ROUTE_BIT  7
// reset values and sizes
`define SBS_RESET_BYTE     8'h00
`define SBS_MODE_OFF       2'h0
`define SBS_DEPTH          32
`define SBS_AXIS_BYTES     2
`define SBS_AXES           3
`endif

// *** common/sbs_pkg.sv ***
package sbs_pkg;
  // burst readout position within one triplet
  typedef enum logic [1:0] {
    SBS_AX_X,
    SBS_AX_Y,
    SBS_AX_Z
  } sbs_axis_type;
  typedef logic [7:0] sbs_byte_type;
endpackage : sbs_pkg

// *** core/sbs_buffer_status.sv ***
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "sbs_params.svh"

module sbs_buffer_status #(
  parameter int DEPTH  = `SBS_DEPTH,
  parameter int SWIDTH = 12
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // incoming samples
  input  wire logic              sample_valid,
  input  wire logic [3*SWIDTH-1:0] sample_xyz,
  // interrupts
  output logic             irq,
  output logic             interrupt_pin_one,
  output logic             interrupt_pin_two
);

  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = $clog2(DEPTH);

  // configuration and state
  logic [7:0]          buffer_config_one;
  logic [7:0]          buffer_config_two;
  logic [7:0]          sensor_config_two;
  logic [7:0]          int_mask;
  logic [7:0]          int_stat;
  logic [CW-1:0]       sample_count;
  logic                watermark_flag;
  logic                overflow_flag;
  logic [PW-1:0]       wr_ptr;
  logic [3*SWIDTH-1:0] mem [DEPTH];
  sbs_pkg::sbs_axis_type axis;
  logic                hi_next;
  logic                wmrk_q;

  // address decode
  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a == {2'h0, idx, 2'h0});
  endfunction : hit

  wire acc        = psel & penable & pready;
  wire wr         = acc & pwrite;
  wire rd         = acc & ~pwrite;
  wire sel_st     = hit(paddr, `SBS_IDX_STATUS);
  wire sel_c1     = hit(paddr, `SBS_IDX_CONFIG_ONE);
  wire sel_c2     = hit(paddr, `SBS_IDX_CONFIG_TWO);
  wire sel_s2     = hit(paddr, `SBS_IDX_SENSOR_TWO);
  wire sel_msk    = hit(paddr, `SBS_IDX_INT_MASK);
  wire sel_ist    = hit(paddr, `SBS_IDX_INT_STAT);
  wire sel_dat    = hit(paddr, `SBS_IDX_DATA);
  wire mapped     = sel_st | sel_c1 | sel_c2 | sel_s2 | sel_msk | sel_ist | sel_dat;
  wire [1:0] mode = buffer_config_one[`SBS_CFG1_MODE_LSB +: 2];
  wire enabled    = (mode != `SBS_MODE_OFF);
  wire fast       = sensor_config_two[`SBS_SEN2_FREAD_BIT];
  wire lifo       = buffer_config_one[`SBS_CFG1_ORDER_BIT];
  wire [5:0] wlvl = buffer_config_two[5:0];

  // control events
  wire flush      = wr & sel_c2 & pwdata[`SBS_CFG2_FLUSH_BIT];
  wire disable_wr = wr & sel_c1 & (pwdata[1:0] == `SBS_MODE_OFF);
  wire clr_all    = flush | disable_wr | ~enabled;
  wire full       = (sample_count == CW'(DEPTH));
  wire push       = sample_valid & enabled & ~full;
  wire ovf_event  = sample_valid & enabled & full;
  // last byte of a triplet: the single z byte (its high part) in fast mode, high byte otherwise
  wire tri_done   = rd & sel_dat & enabled & (sample_count != '0)
                    & (axis == sbs_pkg::SBS_AX_Z) & (fast | hi_next);
  wire pop        = tri_done;

  // read pointer: oldest for fifo, newest for lifo
  wire [PW-1:0] rd_idx = lifo ? PW'(wr_ptr - PW'(1)) : PW'(wr_ptr - PW'(sample_count));
  wire [3*SWIDTH-1:0] cur = mem[rd_idx];
  wire [SWIDTH-1:0] ax_val = (axis == sbs_pkg::SBS_AX_X) ? cur[SWIDTH-1:0] :
                             (axis == sbs_pkg::SBS_AX_Y) ? cur[2*SWIDTH-1:SWIDTH] :
                                                           cur[3*SWIDTH-1:2*SWIDTH];
  // fast read returns the high part at the low address
  wire [7:0] dat_byte = fast ? ax_val[SWIDTH-1 -: 8] :
                        hi_next ? {{(16-SWIDTH){ax_val[SWIDTH-1]}}, ax_val[SWIDTH-1:8]} :
                                  ax_val[7:0];

  // status byte, zero while disabled
  wire [7:0] status_byte = enabled ?
      {watermark_flag, overflow_flag, 6'(sample_count)} : `SBS_RESET_BYTE;

  wire [7:0] rd_byte = sel_st  ? status_byte :
                       sel_c1  ? buffer_config_one :
                       sel_c2  ? {1'b0, buffer_config_two[6:0]} :
                       sel_s2  ? sensor_config_two :
                       sel_msk ? int_mask :
                       sel_ist ? int_stat :
                       sel_dat ? dat_byte : `SBS_RESET_BYTE;

  // next count and flags
  wire [CW-1:0] next_count = clr_all ? '0 :
                             CW'(sample_count + CW'(push) - CW'(pop));
  wire next_wmrk = ~clr_all & (next_count >= CW'(wlvl));
  wire next_ovf  = ~clr_all & (ovf_event | (overflow_flag & ~pop));

  // apb slave registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit(paddr, `SBS_IDX_STATUS) & ~mapped;
      if (psel & ~penable & ~pwrite) prdata <= {24'h0, rd_byte};
    end
  end

  // configuration writes; flush bit self-clears
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      buffer_config_one <= `SBS_RESET_BYTE;
      buffer_config_two <= `SBS_RESET_BYTE;
      sensor_config_two <= `SBS_RESET_BYTE;
      int_mask          <= `SBS_RESET_BYTE;
    end else begin
      if (wr & sel_c1)  buffer_config_one <= pwdata[7:0];
      if (wr & sel_c2)  buffer_config_two <= {1'b0, pwdata[6:0]};
      if (wr & sel_s2)  sensor_config_two <= pwdata[7:0];
      if (wr & sel_msk) int_mask          <= pwdata[7:0];
    end
  end

  // occupancy, flags and storage; count and flags clear on disable
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sample_count   <= '0;
      watermark_flag <= 1'b0;
      overflow_flag  <= 1'b0;
      wr_ptr         <= '0;
    end else begin
      sample_count   <= next_count;
      watermark_flag <= next_wmrk;
      overflow_flag  <= next_ovf;
      if (push) wr_ptr <= PW'(wr_ptr + PW'(1));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) mem[wr_ptr] <= sample_xyz;
  end

  // burst position across data reads; a status read restarts the triplet
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      axis    <= sbs_pkg::SBS_AX_X;
      hi_next <= 1'b0;
    end else if (clr_all | (rd & sel_st)) begin
      axis    <= sbs_pkg::SBS_AX_X;
      hi_next <= 1'b0;
    end else if (rd & sel_dat & (sample_count != '0)) begin
      if (!fast && !hi_next) begin
        hi_next <= 1'b1;
      end else begin
        hi_next <= 1'b0;
        case (axis)
          sbs_pkg::SBS_AX_X: axis <= sbs_pkg::SBS_AX_Y;
          sbs_pkg::SBS_AX_Y: axis <= sbs_pkg::SBS_AX_Z;
          default:           axis <= sbs_pkg::SBS_AX_X;
        endcase
      end
    end
  end

  // sticky interrupt status, cleared by reading it; a new event wins
  wire [7:0] ev = {6'h0, ovf_event, next_wmrk & ~wmrk_q};
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      int_stat <= `SBS_RESET_BYTE;
      wmrk_q   <= 1'b0;
    end else begin
      wmrk_q   <= next_wmrk;
      int_stat <= ((rd & sel_ist) ? 8'h00 : int_stat) | ev;
    end
  end

  // interrupt outputs; watermark routed by mask bit 7
  wire [7:0] next_stat = ((rd & sel_ist) ? 8'h00 : int_stat) | ev;
  wire pend  = |(next_stat[1:0] & int_mask[1:0]);
  wire wpend = next_stat[`SBS_IRQ_WMRK_BIT] & int_mask[`SBS_IRQ_WMRK_BIT];
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irq               <= 1'b0;
      interrupt_pin_one <= 1'b0;
      interrupt_pin_two <= 1'b0;
    end else begin
      irq               <= pend;
      interrupt_pin_one <= wpend & ~int_mask[`SBS_IRQ_ROUTE_BIT];
      interrupt_pin_two <= wpend &  int_mask[`SBS_IRQ_ROUTE_BIT];
    end
  end

  // checks
  a_disabled_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
    (rd & sel_st & ~enabled) |-> ##1 prdata == 32'h0) else $error("status not zero");
  a_count_bound: assert property (@(posedge sys_clk) disable iff (!nrst)
    sample_count <= CW'(DEPTH)) else $error("count above depth");
  a_full_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ovf_event & ~pop & ~clr_all) |=> overflow_flag && sample_count == CW'(DEPTH))
    else $error("overflow not taken");
  a_flush_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
    flush |=> sample_count == '0 && !watermark_flag && !overflow_flag)
    else $error("flush left state");
  a_wmrk_level: assert property (@(posedge sys_clk) disable iff (!nrst)
    (enabled & ~$past(clr_all)) |-> watermark_flag == (sample_count >= CW'(wlvl)))
    else $error("watermark mismatch");
  a_pop_clears: assert property (@(posedge sys_clk) disable iff (!nrst)
    (pop & ~ovf_event) |=> !overflow_flag) else $error("overflow stuck");
  a_disable_clr: assert property (@(posedge sys_clk) disable iff (!nrst)
    disable_wr |=> sample_count == '0 && !overflow_flag) else $error("disable kept state");
  a_pop_count: assert property (@(posedge sys_clk) disable iff (!nrst)
    (pop & ~push & ~clr_all) |=> sample_count == $past(sample_count) - CW'(1))
    else $error("pop no decrement");

endmodule : sbs_buffer_status
`default_nettype wire

// *** sim/sbs_sample_src.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbs_sample_src (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // burst request
  input  wire logic        go,
  input  wire logic [6:0]  num,
  // triplet stream
  output logic             sample_valid,
  output logic [35:0]      sample_xyz
);
  logic [6:0]  left;
  logic [11:0] seq;
  // one triplet a cycle; x negative so sign extension shows
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      left         <= 7'h00;
      seq          <= 12'h8A0;
      sample_valid <= 1'b0;
      sample_xyz   <= 36'h000000000;
    end else begin
      left         <= go ? num : (left != 7'h00 ? left - 7'h01 : left);
      sample_valid <= !go && left != 7'h00;
      if (!go && left != 7'h00) begin
        sample_xyz <= {seq + 12'h002, seq + 12'h001, seq};
        seq        <= seq + 12'h001;
      end else begin
        sample_xyz <= ~sample_xyz; // no stale value between triplets
      end
    end
  end
endmodule : sbs_sample_src
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sbs_params.svh"
module tb_top;
  logic        sys_clk = 1'b0;
  logic        nrst    = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h00000000;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, pin1, pin2, svalid, go = 1'b0, last_err;
  logic [35:0] sxyz;
  logic [6:0]  num     = 7'h00;
  logic [7:0]  r;
  int          bad_count = 0;
  int          comparisons = 0;
  // clock
  always #5 sys_clk = ~sys_clk;
  sbs_buffer_status u_dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_valid(svalid), .sample_xyz(sxyz), .irq(irq),
    .interrupt_pin_one(pin1), .interrupt_pin_two(pin2));
  sbs_sample_src u_src (.sys_clk(sys_clk), .nrst(nrst), .go(go), .num(num),
    .sample_valid(svalid), .sample_xyz(sxyz));
  task automatic finish_test;
    if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // one apb transfer; register index times four is the byte address
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) bad_count++;
    r        = prdata[7:0];
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rc(input logic [7:0] idx, input logic [7:0] e, input string s);
    apb(1'b0, idx, 8'h00);
    chk(s, e, r);
  endtask : rc
  task automatic push(input logic [6:0] n);
    go  <= 1'b1;
    num <= n;
    @(posedge sys_clk);
    go  <= 1'b0;
    repeat (int'(n) + 3) @(posedge sys_clk);
  endtask : push
  task automatic drain(input int n, input logic [7:0] st);
    rc(`SBS_IDX_STATUS, st, "burst status");
    repeat (n) apb(1'b0, `SBS_IDX_DATA, 8'h00);
  endtask : drain
  task automatic s_reset;
    rc(`SBS_IDX_STATUS, 8'h00, "status at reset");
    push(7'd2);
    rc(`SBS_IDX_STATUS, 8'h00, "status disabled");
    rc(8'h40, 8'h00, "unmapped read");
    chk("unmapped error", 8'h01, {7'h00, last_err});
  endtask : s_reset
  task automatic s_wmrk;
    apb(1'b1, `SBS_IDX_CONFIG_TWO, 8'h03);
    apb(1'b1, `SBS_IDX_CONFIG_ONE, 8'h01);
    push(7'd2);
    rc(`SBS_IDX_STATUS, 8'h02, "below level");
    push(7'd1);
    rc(`SBS_IDX_STATUS, 8'h83, "at level");
    apb(1'b1, `SBS_IDX_INT_MASK, 8'h01);
    repeat (2) @(posedge sys_clk);
    chk("pins one", 8'h05, {5'h00, irq, pin2, pin1});
    apb(1'b1, `SBS_IDX_INT_MASK, 8'h81);
    repeat (2) @(posedge sys_clk);
    chk("pins two", 8'h06, {5'h00, irq, pin2, pin1});
    rc(`SBS_IDX_INT_STAT, 8'h01, "event sticky");
    rc(`SBS_IDX_INT_STAT, 8'h00, "event cleared");
    repeat (2) @(posedge sys_clk);
    chk("irq low", 8'h00, {7'h00, irq});
  endtask : s_wmrk
  task automatic s_read;
    logic [7:0] exp_b [6];
    exp_b = '{8'hA2, 8'hF8, 8'hA3, 8'hF8, 8'hA4, 8'hF8};
    rc(`SBS_IDX_STATUS, 8'h83, "burst head");
    for (int i = 0; i < 6; i++) rc(`SBS_IDX_DATA, exp_b[i], "oldest byte");
    rc(`SBS_IDX_STATUS, 8'h02, "after pop");
  endtask : s_read
  task automatic s_ovf;
    push(7'd40);
    rc(`SBS_IDX_STATUS, 8'hE0, "overflow full");
    drain(6, 8'hE0);
    rc(`SBS_IDX_STATUS, 8'h9F, "overflow read");
    push(7'd2);
    apb(1'b1, `SBS_IDX_CONFIG_TWO, 8'h83);
    rc(`SBS_IDX_STATUS, 8'h00, "after flush");
  endtask : s_ovf
  task automatic s_mode;
    push(7'd40);
    apb(1'b1, `SBS_IDX_CONFIG_ONE, 8'h00);
    rc(`SBS_IDX_STATUS, 8'h00, "mode off");
    apb(1'b1, `SBS_IDX_CONFIG_ONE, 8'h01);
    rc(`SBS_IDX_STATUS, 8'h00, "mode back");
  endtask : s_mode
  task automatic s_fast;
    apb(1'b1, `SBS_IDX_SENSOR_TWO, 8'h01);
    push(7'd2);
    drain(2, 8'h02);
    rc(`SBS_IDX_STATUS, 8'h02, "fast partial");
    drain(3, 8'h02);
    rc(`SBS_IDX_STATUS, 8'h01, "fast triplet");
  endtask : s_fast
  task automatic s_lifo;
    apb(1'b1, `SBS_IDX_SENSOR_TWO, 8'h00);
    apb(1'b1, `SBS_IDX_CONFIG_ONE, 8'h05);
    push(7'd1);
    rc(`SBS_IDX_STATUS, 8'h02, "lifo status");
    rc(`SBS_IDX_DATA, 8'hF9, "newest low");
    rc(`SBS_IDX_DATA, 8'hF8, "newest high");
  endtask : s_lifo
  // reset then scenarios
  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    s_reset();
    s_wmrk();
    s_read();
    s_ovf();
    s_mode();
    s_fast();
    s_lifo();
    finish_test();
  end
  // watchdog
  initial begin
    #100000;
    bad_count++;
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
